// file: rtl/iorl_regs.sv
// register file and decoder for the low i/o register space, 0x00..0x22
// assumes the core presents at most one access per cycle; if several
// arrive together the i/o path wins, then load/store, then bit ops
`timescale 1ns/1ns

// Behaviour
// RULE1: bit set and clear work only on i/o addresses 0x00 to 0x1F.
// RULE2: a bit of a bit-accessible register can be tested to skip on one or zero.
// RULE3: a status flag is cleared by writing one to it, and writing zero leaves it.
// RULE4: bit set or clear changes only the addressed bit and clears no other flag.
// RULE5: the i/o read and write path addresses registers by i/o address 0x00 to 0x3F.
// RULE6: on the load/store path every register appears at its i/o address plus 0x20.
// RULE7: software never writes reserved i/o addresses such as 0x1F.
// RULE8: software writes zero to reserved bits whenever it writes a register.
// RULE9: watchdog control sits at 0x21 with flag 7, irq enable 6, change enable 4, reset enable 3.
// RULE10: reserved bits and addresses read zero and writes to them change nothing.
// RULE11: a load/store address minus the offset gives the i/o address of the same register.
module iorl_regs
    import iorl_pkg::*;
#(
    parameter int unsigned DS_AW = 16
) (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        io_read,
    input  wire logic                        io_write,
    input  wire logic [5:0]                  io_addr,
    input  wire logic [7:0]                  io_wdata,
    input  wire logic                        memory_read_op,
    input  wire logic                        memory_write_op,
    input  wire logic [DS_AW-1:0]            mem_addr,
    input  wire logic [7:0]                  mem_wdata,
    input  wire logic                        bit_op_valid,
    input  wire iorl_bitop_e                 bit_op,
    input  wire logic [4:0]                  bit_addr,
    input  wire logic [2:0]                  bit_sel,
    input  wire logic [IORL_NREG-1:0][7:0]   live_in,
    input  wire logic [IORL_NREG-1:0][7:0]   flag_set,
    output logic      [7:0]                  rd_data_q,
    output logic                             rd_valid_q,
    output logic                             rd_hit_q,
    output logic                             skip_valid_q,
    output logic                             skip_taken_q,
    output logic      [IORL_NREG-1:0]        wr_strobe_q,
    output logic      [7:0]                  wr_data_q,
    output logic      [7:0]                  wr_mask_q,
    output logic      [IORL_NREG-1:0][7:0]   reg_out,
    output logic                             watchdog_irq_flag,
    output logic                             watchdog_irq_enable,
    output logic                             watchdog_change_enable,
    output logic                             watchdog_reset_enable
);

    // ==========================================================
    // helpers
    function automatic logic [7:0] bit_onehot(input logic [2:0] sel);
        bit_onehot = 8'h01 << sel;
    endfunction

    localparam logic [DS_AW-1:0] DS_LO = DS_AW'(IORL_DS_OFFSET);
    localparam logic [DS_AW-1:0] DS_HI = DS_AW'(IORL_DS_TOP);

    // ==========================================================
    // load/store window translation
    logic [DS_AW-1:0] mem_diff;
    logic [5:0]       mem_io_addr;
    logic             mem_in_io;

    assign mem_in_io   = (mem_addr >= DS_LO) && (mem_addr <= DS_HI); // RULE6
    assign mem_diff    = mem_addr - DS_LO; // RULE11
    assign mem_io_addr = mem_diff[5:0]; // RULE11

    // ==========================================================
    // access arbitration
    logic       io_acc;
    logic       mem_acc;
    logic       bit_wr;
    logic       skip_req;
    logic [5:0] acc_addr;
    logic       acc_wr;
    logic       acc_rd;
    logic [7:0] acc_wdata;
    logic [7:0] acc_wmask;
    logic       acc_hit;

    assign io_acc   = io_read | io_write; // RULE5
    assign mem_acc  = (memory_read_op | memory_write_op) & mem_in_io;
    // a 5-bit bit address cannot reach above 0x1f
    assign bit_wr   = ~io_acc & ~mem_acc & bit_op_valid
                    & ((bit_op == bit_set_op) | (bit_op == bit_clear_op)); // RULE1
    assign skip_req = ~io_acc & ~mem_acc & bit_op_valid
                    & ((bit_op == skip_on_one_op)
                    |  (bit_op == skip_on_zero_op)); // RULE2

    assign acc_addr  = io_acc  ? io_addr
                     : mem_acc ? mem_io_addr
                     : {1'b0, bit_addr}; // RULE5 RULE11
    assign acc_wr    = io_acc  ? io_write
                     : mem_acc ? memory_write_op
                     : bit_wr;
    assign acc_rd    = io_acc  ? io_read
                     : mem_acc ? memory_read_op
                     : 1'b0;
    // bit set writes a one, bit clear a zero, both into one lane only
    assign acc_wdata = (io_acc | mem_acc) ? (io_acc ? io_wdata : mem_wdata)
                     : {8{bit_op == bit_set_op}};
    assign acc_wmask = (io_acc | mem_acc) ? 8'hff
                     : bit_onehot(bit_sel); // RULE4
    assign acc_hit   = acc_addr <= IORL_LAST_ADDR;

    // ==========================================================
    // register bank
    logic [7:0] regs_q [IORL_NREG];
    logic [7:0] view   [IORL_NREG];
    logic [IORL_NREG-1:0] wr_sel;

    genvar r;
    generate
        for (r = 0; r < IORL_NREG; r++) begin : g_reg
            logic [7:0] we_rw;
            logic [7:0] clr;
            logic [7:0] regs_d;

            assign wr_sel[r] = acc_wr & acc_hit & (acc_addr == 6'(r));
            assign we_rw     = {8{wr_sel[r]}} & acc_wmask & IORL_RW_MASK[r];
            // only bits inside the write mask can clear a flag
            assign clr       = {8{wr_sel[r]}} & acc_wmask & acc_wdata
                             & IORL_W1C_MASK[r]; // RULE3 RULE4
            // a flag raised in the same cycle as its clear survives
            assign regs_d    = (((regs_q[r] & ~we_rw) | (acc_wdata & we_rw))
                             & ~clr | (flag_set[r] & IORL_W1C_MASK[r]))
                             & (IORL_RW_MASK[r] | IORL_W1C_MASK[r]); // RULE3 RULE10

            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    regs_q[r] <= IORL_REG_RESET;
                end else begin
                    regs_q[r] <= regs_d;
                end
            end

            // live bits bypass storage; anything unclassed reads zero
            assign view[r]    = (regs_q[r] & (IORL_RW_MASK[r]
                              | IORL_W1C_MASK[r]) & ~IORL_LIVE_MASK[r])
                              | (live_in[r] & IORL_LIVE_MASK[r]); // RULE10
            assign reg_out[r] = regs_q[r];
        end
    endgenerate

    // ==========================================================
    // read and skip answers
    logic [7:0] rd_mux;
    logic       skip_bit;
    logic       skip_hit;

    assign rd_mux   = acc_hit ? view[acc_addr] : 8'h00; // RULE10
    assign skip_bit = view[{1'b0, bit_addr}][bit_sel]; // RULE2
    assign skip_hit = (bit_op == skip_on_one_op) ? skip_bit : ~skip_bit; // RULE2

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q    <= 8'h00;
            rd_valid_q   <= 1'b0;
            rd_hit_q     <= 1'b0;
            skip_valid_q <= 1'b0;
            skip_taken_q <= 1'b0;
        end else begin
            rd_data_q    <= acc_rd ? rd_mux : 8'h00;
            rd_valid_q   <= acc_rd;
            rd_hit_q     <= acc_rd & acc_hit;
            skip_valid_q <= skip_req;
            skip_taken_q <= skip_req & skip_hit;
        end
    end

    // ==========================================================
    // write notification for peripherals with strobe-only bits
    // strobes fire on any write to 0x00..0x22, so units such as the data buffer can
    // react even to bits that are not stored here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_strobe_q <= '0;
            wr_data_q   <= 8'h00;
            wr_mask_q   <= 8'h00;
        end else begin
            wr_strobe_q <= wr_sel;
            wr_data_q   <= acc_wr ? acc_wdata : 8'h00;
            wr_mask_q   <= acc_wr ? acc_wmask : 8'h00;
        end
    end

    // ==========================================================
    // watchdog control fields
    assign watchdog_irq_flag      =
        regs_q[ADDR_WATCHDOG_CONTROL][WATCHDOG_IRQ_FLAG_BIT]; // RULE9
    assign watchdog_irq_enable    =
        regs_q[ADDR_WATCHDOG_CONTROL][WATCHDOG_IRQ_ENABLE_BIT]; // RULE9
    assign watchdog_change_enable =
        regs_q[ADDR_WATCHDOG_CONTROL][WATCHDOG_CHANGE_ENABLE_BIT]; // RULE9
    assign watchdog_reset_enable  =
        regs_q[ADDR_WATCHDOG_CONTROL][WATCHDOG_RESET_ENABLE_BIT]; // RULE9

endmodule // iorl_regs

// file: rtl/iorl_pkg.sv
// constants for the low i/o register space decoder (i/o 0x00 to 0x22)
// assumes a single system clock shared with the processor core
package iorl_pkg;

    // ==========================================================
    // address space
    localparam int unsigned  IORL_NREG       = 35;
    localparam logic [5:0]   IORL_LAST_ADDR  = 6'h22;
    localparam logic [5:0]   IORL_IO_TOP     = 6'h3f;
    localparam logic [5:0]   IORL_BITOP_TOP  = 6'h1f;
    localparam logic [15:0]  IORL_DS_OFFSET  = 16'h0020;
    localparam logic [15:0]  IORL_DS_TOP     = 16'h005f;

    // ==========================================================
    // register offsets (i/o addresses)
    localparam logic [5:0] ADDR_SERIAL_SHIFT_BUFFER       = 6'h00;
    localparam logic [5:0] ADDR_DIGITAL_INPUT_DISABLE     = 6'h01;
    localparam logic [5:0] ADDR_BAUD_DIVIDER_HIGH         = 6'h02;
    localparam logic [5:0] ADDR_UART_CONTROL_C            = 6'h03;
    localparam logic [5:0] ADDR_PIN_CHANGE_MASK_1         = 6'h04;
    localparam logic [5:0] ADDR_PIN_CHANGE_MASK_2         = 6'h05;
    localparam logic [5:0] ADDR_POWER_REDUCTION           = 6'h06;
    localparam logic [5:0] ADDR_BROWNOUT_SLEEP_CONTROL    = 6'h07;
    localparam logic [5:0] ADDR_ANALOG_COMPARATOR_CONTROL = 6'h08;
    localparam logic [5:0] ADDR_BAUD_DIVIDER_LOW          = 6'h09;
    localparam logic [5:0] ADDR_UART_CONTROL_B            = 6'h0a;
    localparam logic [5:0] ADDR_UART_STATUS_A             = 6'h0b;
    localparam logic [5:0] ADDR_UART_DATA                 = 6'h0c;
    localparam logic [5:0] ADDR_SERIAL_SHIFT_CONTROL      = 6'h0d;
    localparam logic [5:0] ADDR_SERIAL_SHIFT_STATUS       = 6'h0e;
    localparam logic [5:0] ADDR_SERIAL_SHIFT_DATA         = 6'h0f;
    localparam logic [5:0] ADDR_PORT_D_PIN_INPUT          = 6'h10;
    localparam logic [5:0] ADDR_PORT_D_DIRECTION          = 6'h11;
    localparam logic [5:0] ADDR_PORT_D_OUTPUT_LATCH       = 6'h12;
    localparam logic [5:0] ADDR_GENERAL_SCRATCH_0         = 6'h13;
    localparam logic [5:0] ADDR_GENERAL_SCRATCH_1         = 6'h14;
    localparam logic [5:0] ADDR_GENERAL_SCRATCH_2         = 6'h15;
    localparam logic [5:0] ADDR_PORT_B_PIN_INPUT          = 6'h16;
    localparam logic [5:0] ADDR_PORT_B_DIRECTION          = 6'h17;
    localparam logic [5:0] ADDR_PORT_B_OUTPUT_LATCH       = 6'h18;
    localparam logic [5:0] ADDR_PORT_A_PIN_INPUT          = 6'h19;
    localparam logic [5:0] ADDR_PORT_A_DIRECTION          = 6'h1a;
    localparam logic [5:0] ADDR_PORT_A_OUTPUT_LATCH       = 6'h1b;
    localparam logic [5:0] ADDR_EEPROM_CONTROL            = 6'h1c;
    localparam logic [5:0] ADDR_EEPROM_DATA               = 6'h1d;
    localparam logic [5:0] ADDR_EEPROM_ADDRESS            = 6'h1e;
    localparam logic [5:0] ADDR_RESERVED_SLOT             = 6'h1f;
    localparam logic [5:0] ADDR_PIN_CHANGE_MASK_0         = 6'h20;
    localparam logic [5:0] ADDR_WATCHDOG_CONTROL          = 6'h21;
    localparam logic [5:0] ADDR_TIMER1_FORCE_COMPARE      = 6'h22;

    // ==========================================================
    // watchdog control fields
    localparam int unsigned WATCHDOG_IRQ_FLAG_BIT      = 7;
    localparam int unsigned WATCHDOG_IRQ_ENABLE_BIT    = 6;
    localparam int unsigned WATCHDOG_CHANGE_ENABLE_BIT = 4;
    localparam int unsigned WATCHDOG_RESET_ENABLE_BIT  = 3;
    localparam logic [7:0]  IORL_WDT_W1C = 8'h01 << WATCHDOG_IRQ_FLAG_BIT;
    localparam logic [7:0]  IORL_WDT_RW  = ~IORL_WDT_W1C;

    // ==========================================================
    // per-register bit classes, indexed by i/o address
    // rw: stored by writes; w1c: set by hardware, cleared by a one;
    // live: read straight from the peripheral side
    localparam logic [7:0] IORL_RW_MASK [IORL_NREG] = '{
        8'h00, 8'h03, 8'h0f, 8'hff, 8'h07, 8'h7f, 8'h0f, 8'h03,
        8'hcf, 8'hff, 8'hfd, 8'h03, 8'hff, 8'hfc, 8'h0f, 8'hff,
        8'h00, 8'h7f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff,
        8'hff, 8'h00, 8'h07, 8'h07, 8'h3f, 8'hff, 8'h7f, 8'h00,
        8'hff, IORL_WDT_RW, 8'h00};
    localparam logic [7:0] IORL_W1C_MASK [IORL_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h10, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'he0, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, IORL_WDT_W1C, 8'h00};
    localparam logic [7:0] IORL_LIVE_MASK [IORL_NREG] = '{
        8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h20, 8'h00, 8'h02, 8'hbc, 8'hff, 8'h00, 8'h10, 8'h00,
        8'h7f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00,
        8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    localparam logic [7:0] IORL_REG_RESET = 8'h00;

    // ==========================================================
    // single-bit operations
    typedef enum logic [1:0] {
        bit_set_op,
        bit_clear_op,
        skip_on_one_op,
        skip_on_zero_op
    } iorl_bitop_e;

endpackage

// file: dv/iorl_regs_checker.sv
// assertions for the low i/o register decoder
// sees only iorl_regs ports; bound from the bench top file
`timescale 1ns/1ns
module iorl_regs_checker
    import iorl_pkg::*;
#(
    parameter int unsigned DS_AW = 16
) (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  io_read,
    input wire logic                  io_write,
    input wire logic [5:0]            io_addr,
    input wire logic [7:0]            io_wdata,
    input wire logic                  memory_read_op,
    input wire logic                  memory_write_op,
    input wire logic [DS_AW-1:0]      mem_addr,
    input wire logic                  bit_op_valid,
    input wire iorl_bitop_e           bit_op,
    input wire logic [4:0]            bit_addr,
    input wire logic [2:0]            bit_sel,
    input wire logic [7:0]            rd_data_q,
    input wire logic                  rd_valid_q,
    input wire logic                  rd_hit_q,
    input wire logic                  skip_valid_q,
    input wire logic [IORL_NREG-1:0]  wr_strobe_q,
    input wire logic [7:0]            wr_data_q,
    input wire logic [7:0]            wr_mask_q,
    input wire logic [IORL_NREG-1:0][7:0] reg_out,
    input wire logic                  watchdog_irq_flag,
    input wire logic                  watchdog_irq_enable,
    input wire logic                  watchdog_change_enable,
    input wire logic                  watchdog_reset_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // lower-priority requests only count when nothing above them is asked
    wire logic io_idle = !io_read && !io_write;
    wire logic ds_in = mem_addr >= 16'h0020 && mem_addr <= 16'h005f;
    wire logic bit_go = io_idle && !memory_read_op && !memory_write_op
                        && bit_op_valid;
    property p_io_read;
        io_read |=> rd_valid_q && rd_hit_q == ($past(io_addr) <= 6'h22)
            && (rd_hit_q || rd_data_q == 8'h00); endproperty
    a_io_read: assert property (p_io_read) else $error("io read");
    property p_ds_map;
        io_idle && memory_read_op |=> rd_valid_q == $past(ds_in); endproperty
    a_ds_map: assert property (p_ds_map) else $error("ds map");
    property p_ds_hit; io_idle && memory_read_op && ds_in
        |=> rd_hit_q == ($past(mem_addr) <= 16'h0042); endproperty
    a_ds_hit: assert property (p_ds_hit) else $error("ds hit");
    property p_io_wr; io_write && !io_read && io_addr <= 6'h22
        |=> wr_strobe_q == (35'h0_0000_0001 << $past(io_addr))
            && wr_mask_q == 8'hff && wr_data_q == $past(io_wdata); endproperty
    a_io_wr: assert property (p_io_wr) else $error("io write");
    property p_bit_set; bit_go && bit_op == bit_set_op
        |=> wr_strobe_q == (35'h0_0000_0001 << $past(bit_addr))
            && wr_mask_q == (8'h01 << $past(bit_sel)); endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit set");
    property p_bit_clr; bit_go && bit_op == bit_clear_op
        |=> wr_mask_q == (8'h01 << $past(bit_sel)) && wr_data_q == 8'h00;
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit clear");
    property p_skip; bit_go && bit_op inside {skip_on_one_op, skip_on_zero_op}
        |=> skip_valid_q && wr_strobe_q == '0; endproperty
    a_skip: assert property (p_skip) else $error("skip");
    property p_w1c;
        $fell(watchdog_irq_flag) |-> wr_strobe_q[33] && wr_data_q[7]; endproperty
    a_w1c: assert property (p_w1c) else $error("flag drop");
    property p_wdt; {watchdog_irq_flag, watchdog_irq_enable,
        watchdog_change_enable, watchdog_reset_enable}
        == {reg_out[33][7:6], reg_out[33][4:3]}; endproperty
    a_wdt: assert property (p_wdt) else $error("wdt bits");
    property p_rsvd; reg_out[31] == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved");
    c_miss: cover property (io_read && io_addr > 6'h22);
    c_skip: cover property (skip_valid_q);
    c_w1c: cover property ($fell(watchdog_irq_flag));
endmodule // iorl_regs_checker

// file: dv/iorl_core.sv
// processor core model: one access per call, then one idle cycle
// assumes the bench clock and the iorl_regs request ports
`timescale 1ns/1ns
module iorl_core
    import iorl_pkg::*;
(
    input  wire logic   clock,
    output logic        io_read,
    output logic        io_write,
    output logic [5:0]  io_addr,
    output logic [7:0]  io_wdata,
    output logic        memory_read_op,
    output logic        memory_write_op,
    output logic [15:0] mem_addr,
    output logic [7:0]  mem_wdata,
    output logic        bit_op_valid,
    output iorl_bitop_e bit_op,
    output logic [4:0]  bit_addr,
    output logic [2:0]  bit_sel
);
    initial begin
        {io_read, io_write, memory_read_op, memory_write_op} = '0;
        {bit_op_valid, io_addr, io_wdata, mem_addr, mem_wdata} = '0;
        {bit_addr, bit_sel} = '0;
        bit_op = bit_set_op;
    end
    // kind: 0 in, 1 out, 2 load, 3 store, 4..7 bit op (a = addr, d = sel)
    // callers write reserved bits and reserved slots only to probe them
    task automatic acc(input logic [2:0] kind, input logic [15:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        #1;
        io_read = kind == 3'd0;
        io_write = kind == 3'd1;
        memory_read_op = kind == 3'd2;
        memory_write_op = kind == 3'd3;
        bit_op_valid = kind[2];
        bit_op = iorl_bitop_e'(kind[1:0]);
        {io_addr, mem_addr, bit_addr} = {a[5:0], a, a[4:0]};
        {io_wdata, mem_wdata, bit_sel} = {d, d, d[2:0]};
        @(posedge clock);
        #1;
        {io_read, io_write, memory_read_op, memory_write_op} = '0;
        bit_op_valid = 1'b0;
        // released lines flip so a stale value never looks valid
        {io_addr, mem_addr, bit_addr} = ~{io_addr, mem_addr, bit_addr};
        {io_wdata, mem_wdata, bit_sel} = ~{io_wdata, mem_wdata, bit_sel};
    endtask
endmodule // iorl_core

// file: dv/tb_top.sv
// self-checking bench for the low i/o register decoder
// core model issues accesses; bench plays the peripheral side
`timescale 1ns/1ns
module tb_top
    import iorl_pkg::*;
;
    logic             clock, rst_n, io_read, io_write, memory_read_op;
    logic             memory_write_op, bit_op_valid, rd_valid_q, rd_hit_q;
    logic             skip_valid_q, skip_taken_q, watchdog_irq_flag;
    logic             watchdog_irq_enable, watchdog_change_enable;
    logic             watchdog_reset_enable;
    logic [5:0]       io_addr;
    logic [4:0]       bit_addr;
    logic [2:0]       bit_sel;
    logic [15:0]      mem_addr;
    logic [7:0]       io_wdata, mem_wdata, rd_data_q, wr_data_q, wr_mask_q;
    iorl_bitop_e      bit_op;
    logic [IORL_NREG-1:0]      wr_strobe_q;
    logic [IORL_NREG-1:0][7:0] live_in, flag_set, reg_out;
    int               n_mismatch = 0;
    int               checked = 0;
    int               cycles = 0;
    iorl_regs #(.DS_AW(16)) u_iorl_regs (.*);
    iorl_core u_iorl_core (.clock(clock), .io_read(io_read),
        .io_write(io_write), .io_addr(io_addr), .io_wdata(io_wdata),
        .memory_read_op(memory_read_op), .memory_write_op(memory_write_op),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .bit_op(bit_op),
        .bit_op_valid(bit_op_valid), .bit_addr(bit_addr), .bit_sel(bit_sel));
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one-cycle set pulse from the peripheral side
    task automatic raise(input int r, input int b);
        @(posedge clock);
        #1;
        flag_set[r][b] = 1'b1;
        @(posedge clock);
        #1;
        flag_set[r][b] = 1'b0;
    endtask
    task automatic t_paths;
        u_iorl_core.acc(3'd1, 16'h0013, 8'h5a);
        chk("scratch", 8'h5a, reg_out[19]);
        u_iorl_core.acc(3'd2, 16'h0033, 8'h00);
        chk("ds read", 8'h5a, rd_data_q);
        u_iorl_core.acc(3'd3, 16'h0034, 8'ha5);
        u_iorl_core.acc(3'd0, 16'h0014, 8'h00);
        chk("io read", 8'ha5, rd_data_q);
        u_iorl_core.acc(3'd0, 16'h0030, 8'h00);
        chk("miss", 8'h02, {6'h00, rd_valid_q, rd_hit_q});
        u_iorl_core.acc(3'd2, 16'h0060, 8'h00);
        chk("ds range", 8'h00, {7'h00, rd_valid_q});
    endtask
    task automatic t_reserved;
        u_iorl_core.acc(3'd1, 16'h001f, 8'hff);
        u_iorl_core.acc(3'd0, 16'h001f, 8'h00);
        chk("reserved", 8'h00, rd_data_q);
        u_iorl_core.acc(3'd3, 16'h0031, 8'hff);
        chk("dir d", 8'h7f, reg_out[17]);
    endtask
    task automatic t_flags;
        raise(33, 7);
        u_iorl_core.acc(3'd3, 16'h0041, 8'h58);
        chk("wdt", 8'hd8, reg_out[33]);
        u_iorl_core.acc(3'd1, 16'h0021, 8'h80);
        chk("wdt clear", 8'h00, reg_out[33]);
        // raise and clear land on one edge: the raise must survive
        fork
            raise(33, 7);
            u_iorl_core.acc(3'd1, 16'h0021, 8'h80);
        join
        chk("set wins", 8'h80, reg_out[33]);
        u_iorl_core.acc(3'd1, 16'h000b, 8'h03);
        raise(11, 6);
        u_iorl_core.acc(3'd5, 16'h000b, 8'h00);
        chk("flag kept", 8'h42, reg_out[11]);
        u_iorl_core.acc(3'd4, 16'h000b, 8'h06);
        chk("flag clear", 8'h02, reg_out[11]);
    endtask
    task automatic t_skip;
        logic [7:0] e;
        for (int i = 0; i < 4; i++) begin
            e = {6'h00, 1'b1, i[1] ^ i[0]};
            u_iorl_core.acc(3'(6 + i[1]), 16'h0013, 8'(i[0]));
            chk("skip", e, {6'h00, skip_valid_q, skip_taken_q});
        end
        live_in[22] = 8'h80;
        u_iorl_core.acc(3'd6, 16'h0016, 8'h07);
        chk("live skip", 8'h03, {6'h00, skip_valid_q, skip_taken_q});
        u_iorl_core.acc(3'd4, 16'h0013, 8'h00);
        chk("bit set", 8'h5b, reg_out[19]);
        u_iorl_core.acc(3'd5, 16'h0013, 8'h01);
        chk("bit clear", 8'h59, reg_out[19]);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        // the whole sequence needs well under a hundred cycles
        if (cycles == 1000) begin
            n_mismatch++;
            complete_run;
        end
    end
    initial begin
        rst_n = 1'b0;
        live_in = '0;
        flag_set = '0;
        repeat (5) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_paths;
        t_reserved;
        t_flags;
        t_skip;
        complete_run;
    end
endmodule // tb_top

bind iorl_regs iorl_regs_checker #(.DS_AW(DS_AW)) u_iorl_regs_checker (.*);
